// ---- hw/lps_seq.sv ----
// Measurement sequencer, thresholds and persistence for light/near sensing
`timescale 1ns/1ps
`default_nettype none
module lps_seq #(
  parameter int OSC_HZ = lps_pkg::OSC_HZ,
  parameter int CORE_HZ = lps_pkg::CORE_HZ,
  parameter int INT_DIV = lps_pkg::INT_DIV,
  parameter int STEP_ITICKS = lps_pkg::STEP_ITICKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] photopic_data,
  input wire logic [7:0] near_data,
  output logic osc_run,
  output logic light_active,
  output logic near_active,
  output logic wait_active,
  output logic [15:0] light_result,
  output logic [7:0] near_result,
  output logic int_n_o,
  output logic int_n_oe
);

  localparam int UW = lps_pkg::UNIT_W;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Light persistence code to count needed
  function automatic logic [5:0] light_need(input logic [3:0] code);
    logic [5:0] k;
    k = {2'b00, code} - {2'b00, lps_pkg::LIGHT_LIN_CODES};
    if (code <= lps_pkg::LIGHT_LIN_CODES) begin
      light_need = {2'b00, code};
    end else begin
      light_need = 6'((k * lps_pkg::LIGHT_CODE_STRIDE));
    end
  endfunction

  // Largest light count reachable for a step setting
  function automatic logic [15:0] full_scale(input logic [7:0] s);
    if (s >= lps_pkg::FS_SAT_STEPS) begin
      full_scale = lps_pkg::FS_MAX;
    end else begin
      full_scale = {s[5:0], lps_pkg::FS_STEP_LSBS};
    end
  endfunction

  // Address match used by every register write strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] enable_reg;
  logic [7:0] light_steps_reg;
  logic [7:0] near_steps_reg;
  logic [7:0] wait_steps_reg;
  logic [7:0] llo_buf_reg;
  logic [7:0] lhi_buf_reg;
  logic [15:0] light_low_thr_reg;
  logic [15:0] light_high_thr_reg;
  logic [7:0] near_low_limit_reg;
  logic [7:0] near_high_limit_reg;
  logic [7:0] filter_counts_reg;
  logic [7:0] cfg0_reg;
  logic [7:0] irq_en_reg;
  logic light_irq_flag_reg;
  logic near_irq_flag_reg;
  logic [5:0] light_cnt_reg;
  logic [3:0] near_cnt_reg;
  logic [15:0] light_result_reg;
  logic [7:0] near_result_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic [31:0] acc_reg;
  logic [3:0] div_reg;
  logic int_tick_reg;
  lps_pkg::lps_state_t state_reg;
  lps_pkg::lps_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // Field views

  wire power_up_bit = enable_reg[lps_pkg::BIT_POWER];
  wire light_measure_on = enable_reg[lps_pkg::BIT_LIGHT_ON];
  wire near_detect_on = enable_reg[lps_pkg::BIT_NEAR_ON];
  wire wait_on = enable_reg[lps_pkg::BIT_WAIT_ON];
  wire wait_stretch = cfg0_reg[lps_pkg::BIT_STRETCH];
  wire light_irq_allow = irq_en_reg[lps_pkg::BIT_LIGHT_IRQ];
  wire near_irq_allow = irq_en_reg[lps_pkg::BIT_NEAR_IRQ];
  wire [3:0] near_filter_count = filter_counts_reg[7:4];
  wire [3:0] light_filter_count = filter_counts_reg[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Write strobes

  wire wr_enable = reg_wr && hit(reg_addr, lps_pkg::ADDR_ENABLE);
  wire wr_lsteps = reg_wr && hit(reg_addr, lps_pkg::ADDR_LIGHT_STEPS);
  wire wr_nsteps = reg_wr && hit(reg_addr, lps_pkg::ADDR_NEAR_STEPS);
  wire wr_wsteps = reg_wr && hit(reg_addr, lps_pkg::ADDR_WAIT_STEPS);
  wire wr_llo_lo = reg_wr && hit(reg_addr, lps_pkg::ADDR_LLO_LO);
  wire wr_llo_hi = reg_wr && hit(reg_addr, lps_pkg::ADDR_LLO_HI);
  wire wr_lhi_lo = reg_wr && hit(reg_addr, lps_pkg::ADDR_LHI_LO);
  wire wr_lhi_hi = reg_wr && hit(reg_addr, lps_pkg::ADDR_LHI_HI);
  wire wr_nlo = reg_wr && hit(reg_addr, lps_pkg::ADDR_NEAR_LO);
  wire wr_nhi = reg_wr && hit(reg_addr, lps_pkg::ADDR_NEAR_HI);
  wire wr_filter = reg_wr && hit(reg_addr, lps_pkg::ADDR_FILTER);
  wire wr_cfg0 = reg_wr && hit(reg_addr, lps_pkg::ADDR_CFG0);
  wire wr_status = reg_wr && hit(reg_addr, lps_pkg::ADDR_STATUS);
  wire wr_irq_en = reg_wr && hit(reg_addr, lps_pkg::ADDR_IRQ_EN);

  // Configuration registers; reserved enable bits stay zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_reg <= lps_pkg::RST_ZERO;
      light_steps_reg <= lps_pkg::RST_ZERO;
      near_steps_reg <= lps_pkg::RST_NEAR_STEPS;
      wait_steps_reg <= lps_pkg::RST_ZERO;
      filter_counts_reg <= lps_pkg::RST_ZERO;
      cfg0_reg <= lps_pkg::RST_CFG0;
      irq_en_reg <= lps_pkg::RST_ZERO;
    end else begin
      if (wr_enable) enable_reg <= {4'h0, reg_wdata[lps_pkg::ENABLE_BITS-1:0]};
      if (wr_lsteps) light_steps_reg <= reg_wdata;
      if (wr_nsteps) near_steps_reg <= reg_wdata;
      if (wr_wsteps) wait_steps_reg <= reg_wdata;
      if (wr_filter) filter_counts_reg <= reg_wdata;
      if (wr_cfg0) cfg0_reg <= reg_wdata;
      if (wr_irq_en) irq_en_reg <= reg_wdata;
    end
  end

  // Threshold low bytes wait in buffers so the comparator never sees
  // a half-updated 16-bit value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      llo_buf_reg <= lps_pkg::RST_ZERO;
      lhi_buf_reg <= lps_pkg::RST_ZERO;
      light_low_thr_reg <= 16'h0000;
      light_high_thr_reg <= 16'h0000;
      near_low_limit_reg <= lps_pkg::RST_ZERO;
      near_high_limit_reg <= lps_pkg::RST_ZERO;
    end else begin
      if (wr_llo_lo) llo_buf_reg <= reg_wdata;
      if (wr_lhi_lo) lhi_buf_reg <= reg_wdata;
      if (wr_llo_hi) light_low_thr_reg <= {reg_wdata, llo_buf_reg};
      if (wr_lhi_hi) light_high_thr_reg <= {reg_wdata, lhi_buf_reg};
      if (wr_nlo) near_low_limit_reg <= reg_wdata;
      if (wr_nhi) near_high_limit_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator and integration clock ticks

  // Fractional accumulator: averages OSC_HZ ticks at the core rate,
  // jitter is one core cycle, which is far below a step
  wire [31:0] acc_sum = acc_reg + 32'(OSC_HZ);
  wire osc_tick = (acc_sum >= 32'(CORE_HZ));
  wire div_end = (div_reg == 4'(INT_DIV - 1));

  always_ff @(posedge core_clk) begin
    if (srst || !power_up_bit) begin
      acc_reg <= 32'h0000_0000;
      div_reg <= 4'h0;
      int_tick_reg <= 1'b0;
    end else begin
      acc_reg <= osc_tick ? acc_sum - 32'(CORE_HZ) : acc_sum;
      if (osc_tick) div_reg <= div_end ? 4'h0 : div_reg + 4'h1;
      int_tick_reg <= osc_tick && div_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase timer

  logic tmr_load;
  logic tmr_done;
  logic tmr_busy;
  logic [7:0] tmr_steps;
  logic [UW-1:0] tmr_unit;

  // Units: light step, near step, wait step (optionally twelve times)
  wire [UW-1:0] unit_light = UW'(STEP_ITICKS);
  wire [UW-1:0] unit_near = UW'(lps_pkg::NEAR_STEP_ITICKS);
  wire [UW-1:0] unit_wait = wait_stretch ?
      UW'(STEP_ITICKS * lps_pkg::LONG_MULT) : UW'(STEP_ITICKS);

  // Timer setup follows the phase being entered
  assign tmr_steps = (state_next == lps_pkg::LPS_LIGHT) ? light_steps_reg :
                     (state_next == lps_pkg::LPS_NEAR) ? near_steps_reg :
                     wait_steps_reg;
  assign tmr_unit = (state_next == lps_pkg::LPS_LIGHT) ? unit_light :
                    (state_next == lps_pkg::LPS_NEAR) ? unit_near :
                    unit_wait;

  lps_timer #(
    .UNIT_W(UW)
  ) u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .load(tmr_load),
    .steps(tmr_steps),
    .unit_ticks(tmr_unit),
    .tick(int_tick_reg),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Order within one cycle is light, near, wait; disabled phases drop out
  wire any_meas = light_measure_on || near_detect_on;
  lps_pkg::lps_state_t first_ph;
  lps_pkg::lps_state_t after_light;
  lps_pkg::lps_state_t after_near;
  assign first_ph = light_measure_on ? lps_pkg::LPS_LIGHT :
                    near_detect_on ? lps_pkg::LPS_NEAR :
                    lps_pkg::LPS_IDLE;
  assign after_near = wait_on ? lps_pkg::LPS_WAIT : first_ph;
  assign after_light = near_detect_on ? lps_pkg::LPS_NEAR : after_near;

  // Next state and timer load; losing power drops straight to sleep
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    if (!power_up_bit) begin
      state_next = lps_pkg::LPS_SLEEP;
    end else begin
      case (state_reg)
        lps_pkg::LPS_SLEEP: begin
          state_next = lps_pkg::LPS_IDLE;
        end
        lps_pkg::LPS_IDLE: begin
          if (any_meas) begin
            state_next = first_ph;
            tmr_load = 1'b1;
          end
        end
        lps_pkg::LPS_LIGHT: begin
          if (tmr_done) begin
            state_next = after_light;
            tmr_load = (after_light != lps_pkg::LPS_IDLE);
          end
        end
        lps_pkg::LPS_NEAR: begin
          if (tmr_done) begin
            state_next = after_near;
            tmr_load = (after_near != lps_pkg::LPS_IDLE);
          end
        end
        lps_pkg::LPS_WAIT: begin
          if (tmr_done) begin
            state_next = first_ph;
            tmr_load = (first_ph != lps_pkg::LPS_IDLE);
          end
        end
        default: begin
          state_next = lps_pkg::LPS_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= lps_pkg::LPS_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Threshold evaluation at the end of each measurement phase

  wire light_end = (state_reg == lps_pkg::LPS_LIGHT) && tmr_done;
  wire near_end = (state_reg == lps_pkg::LPS_NEAR) && tmr_done;

  // The converter cannot exceed the full scale of the chosen time
  wire [15:0] light_fs = full_scale(light_steps_reg);
  wire [15:0] light_sample = (photopic_data > light_fs) ? light_fs : photopic_data;
  wire light_out = (light_sample < light_low_thr_reg) ||
                   (light_sample > light_high_thr_reg);
  wire near_out = (near_data < near_low_limit_reg) ||
                  (near_data > near_high_limit_reg);

  // Consecutive miss counters saturate so they never wrap back to a match
  wire [5:0] light_cnt_next = !light_out ? 6'h00 :
      (light_cnt_reg == 6'h3f) ? light_cnt_reg : light_cnt_reg + 6'h01;
  wire [3:0] near_cnt_next = !near_out ? 4'h0 :
      (near_cnt_reg == 4'hf) ? near_cnt_reg : near_cnt_reg + 4'h1;

  // Code zero fires on every cycle; a count left over from a stricter code must not mask a lower one
  wire light_fire = light_end && ((light_filter_count == 4'h0) ||
      (light_out && light_cnt_next >= light_need(light_filter_count)));
  wire near_fire = near_end && ((near_filter_count == 4'h0) ||
      (near_out && near_cnt_next >= near_filter_count));

  // Results and counters move only when their phase ran
  always_ff @(posedge core_clk) begin
    if (srst) begin
      light_cnt_reg <= 6'h00;
      near_cnt_reg <= 4'h0;
      light_result_reg <= 16'h0000;
      near_result_reg <= 8'h00;
    end else begin
      if (light_end) begin
        light_cnt_reg <= light_cnt_next;
        light_result_reg <= light_sample;
      end
      if (near_end) begin
        near_cnt_reg <= near_cnt_next;
        near_result_reg <= near_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags and pin

  wire clr_light = wr_status && reg_wdata[lps_pkg::BIT_LIGHT_IRQ];
  wire clr_near = wr_status && reg_wdata[lps_pkg::BIT_NEAR_IRQ];

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      light_irq_flag_reg <= 1'b0;
      near_irq_flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      light_irq_flag_reg <= light_fire || (light_irq_flag_reg && !clr_light);
      near_irq_flag_reg <= near_fire || (near_irq_flag_reg && !clr_near);
      irq_reg <= (light_irq_flag_reg && light_irq_allow) ||
                 (near_irq_flag_reg && near_irq_allow);
    end
  end

  // Open drain: only ever pulls low
  assign int_n_o = 1'b0;
  assign int_n_oe = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      lps_pkg::ADDR_ENABLE: rd_mux = enable_reg;
      lps_pkg::ADDR_LIGHT_STEPS: rd_mux = light_steps_reg;
      lps_pkg::ADDR_NEAR_STEPS: rd_mux = near_steps_reg;
      lps_pkg::ADDR_WAIT_STEPS: rd_mux = wait_steps_reg;
      lps_pkg::ADDR_LLO_LO: rd_mux = llo_buf_reg;
      lps_pkg::ADDR_LLO_HI: rd_mux = light_low_thr_reg[15:8];
      lps_pkg::ADDR_LHI_LO: rd_mux = lhi_buf_reg;
      lps_pkg::ADDR_LHI_HI: rd_mux = light_high_thr_reg[15:8];
      lps_pkg::ADDR_NEAR_LO: rd_mux = near_low_limit_reg;
      lps_pkg::ADDR_NEAR_HI: rd_mux = near_high_limit_reg;
      lps_pkg::ADDR_FILTER: rd_mux = filter_counts_reg;
      lps_pkg::ADDR_CFG0: rd_mux = cfg0_reg;
      lps_pkg::ADDR_STATUS: rd_mux = {2'b00, near_irq_flag_reg, light_irq_flag_reg, 4'h0};
      lps_pkg::ADDR_LRES_LO: rd_mux = light_result_reg[7:0];
      lps_pkg::ADDR_LRES_HI: rd_mux = light_result_reg[15:8];
      lps_pkg::ADDR_NRES: rd_mux = near_result_reg;
      lps_pkg::ADDR_IRQ_EN: rd_mux = irq_en_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign osc_run = power_up_bit;
  assign light_active = (state_reg == lps_pkg::LPS_LIGHT);
  assign near_active = (state_reg == lps_pkg::LPS_NEAR);
  assign wait_active = (state_reg == lps_pkg::LPS_WAIT);
  assign light_result = light_result_reg;
  assign near_result = near_result_reg;

endmodule
`default_nettype wire

// ---- shared/lps_pkg.sv ----
// Constants, register map and state codes for the light/near sequencer
//
// Operation
// - Wait phase runs only when wait enabled
// - Near enable runs proximity sample phase
// - Light enable runs light integration phase
// - Power bit runs oscillator; clear means sleep
// - Integration down counter ends at zero
// - Oscillator divided by 11, 2048 ticks/step
// - Near sample is (setting+1) times 88us
// - Wait down counter, (setting+1) steps
// - Stretch multiplies wait time by twelve
// - Light below low threshold sets flag
// - Light above high threshold sets flag
// - Light flag and allow drive interrupt
// - Threshold low byte buffered until high byte
// - Near outside limits sets near flag
// - Near flag and allow drive interrupt
// - Near filter count in bits 7:4
// - Light filter count in bits 3:0
// - Count consecutive misses, clear when inside
// - Repeat light, near, wait in order
// - Writing one clears a status flag
// - Stretch is bit 2 at 0x8d
package lps_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_ENABLE = 8'h80;
  localparam logic [7:0] ADDR_LIGHT_STEPS = 8'h81;
  localparam logic [7:0] ADDR_NEAR_STEPS = 8'h82;
  localparam logic [7:0] ADDR_WAIT_STEPS = 8'h83;
  localparam logic [7:0] ADDR_LLO_LO = 8'h84;
  localparam logic [7:0] ADDR_LLO_HI = 8'h85;
  localparam logic [7:0] ADDR_LHI_LO = 8'h86;
  localparam logic [7:0] ADDR_LHI_HI = 8'h87;
  localparam logic [7:0] ADDR_NEAR_LO = 8'h88;
  localparam logic [7:0] ADDR_NEAR_HI = 8'h8a;
  localparam logic [7:0] ADDR_FILTER = 8'h8c;
  localparam logic [7:0] ADDR_CFG0 = 8'h8d;
  localparam logic [7:0] ADDR_STATUS = 8'h93;
  localparam logic [7:0] ADDR_LRES_LO = 8'h94;
  localparam logic [7:0] ADDR_LRES_HI = 8'h95;
  localparam logic [7:0] ADDR_NRES = 8'h9c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hdd;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_NEAR_STEPS = 8'h1f;
  localparam logic [7:0] RST_CFG0 = 8'h80;

  // Bit positions
  localparam int BIT_POWER = 0;
  localparam int BIT_LIGHT_ON = 1;
  localparam int BIT_NEAR_ON = 2;
  localparam int BIT_WAIT_ON = 3;
  localparam int BIT_STRETCH = 2;
  localparam int BIT_LIGHT_IRQ = 4;
  localparam int BIT_NEAR_IRQ = 5;
  localparam int ENABLE_BITS = 4;

  // Timing: oscillator, integration clock and step lengths
  localparam int OSC_HZ = 8000000;
  localparam int CORE_HZ = 100000000;
  localparam int INT_DIV = 11;
  localparam int STEP_ITICKS = 2048;
  localparam int INT_CLK_NS = (INT_DIV * 1000) / (OSC_HZ / 1000000);
  localparam int NEAR_STEP_NS = 88000;
  localparam int NEAR_STEP_ITICKS = NEAR_STEP_NS / INT_CLK_NS;
  localparam int LONG_MULT = 12;
  localparam int UNIT_W = 15;

  // Light full scale: 1024 counts per step, saturating
  localparam logic [9:0] FS_STEP_LSBS = 10'h3ff;
  localparam logic [7:0] FS_SAT_STEPS = 8'h40;
  localparam logic [15:0] FS_MAX = 16'hffff;
  localparam logic [3:0] LIGHT_LIN_CODES = 4'h3;
  localparam logic [5:0] LIGHT_CODE_STRIDE = 6'h05;

  typedef enum logic [5:0] {
    LPS_SLEEP = 6'h01,
    LPS_IDLE = 6'h02,
    LPS_LIGHT = 6'h04,
    LPS_NEAR = 6'h08,
    LPS_WAIT = 6'h10,
    LPS_SPARE = 6'h20
  } lps_state_t;

endpackage

// ---- hw/lps_timer.sv ----
// Step down counter clocked by integration ticks
`timescale 1ns/1ps
`default_nettype none
module lps_timer #(
  parameter int UNIT_W = 15
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [7:0] steps,
  input wire logic [UNIT_W-1:0] unit_ticks,
  input wire logic tick,
  output logic busy,
  output logic done
);

  logic [7:0] step_reg;
  logic [UNIT_W-1:0] sub_reg;
  logic [UNIT_W-1:0] unit_reg;
  logic busy_reg;
  wire sub_end = (sub_reg == '0);
  wire last = sub_end && (step_reg == 8'h00);

  // Done is combinational so the sequencer can chain phases with no gap
  assign done = busy_reg && tick && last;
  assign busy = busy_reg;

  // Terminal count 0x00 gives (steps+1) units
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      step_reg <= 8'h00;
      sub_reg <= '0;
      unit_reg <= '0;
    end else if (load) begin
      busy_reg <= 1'b1;
      step_reg <= steps;
      sub_reg <= unit_ticks - 1'b1;
      unit_reg <= unit_ticks;
    end else if (busy_reg && tick) begin
      if (last) begin
        busy_reg <= 1'b0;
      end else if (sub_end) begin
        step_reg <= step_reg - 8'h01;
        sub_reg <= unit_reg - 1'b1;
      end else begin
        sub_reg <= sub_reg - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/lps_seq_assertions.sv ----
// Port checker for the light/near sequencer
`timescale 1ns/1ps
`default_nettype none
module lps_seq_assertions #(
  parameter int INT_DIV = 2,
  parameter int STEP_ITICKS = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_run,
  input wire logic light_active,
  input wire logic near_active,
  input wire logic wait_active,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // Light phase length; step count mirrors host writes
  logic [7:0] steps_reg;
  logic [15:0] cnt_reg;
  int exp_len;
  assign exp_len = (int'(steps_reg) + 1) * STEP_ITICKS * INT_DIV;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      steps_reg <= 8'h00;
      cnt_reg <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == 8'h81) steps_reg <= reg_wdata;
      cnt_reg <= light_active ? cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////
  // Flags cleared only while powered down, so no new set can race it
  sequence flag_clear_s;
    reg_wr && reg_addr == 8'h93 && reg_wdata == 8'h30 && !osc_run;
  endsequence
  // Tick alignment of the divider allows two cycles either way
  sequence light_end_s;
    $fell(light_active) && osc_run && $past(osc_run);
  endsequence
  chk_sleep_quiet: assert property (!osc_run |=> !(light_active || near_active || wait_active))
    else $error("phase active while powered down");
  chk_power_write: assert property (reg_wr && reg_addr == 8'h80 && reg_wdata[0] |=> osc_run)
    else $error("power bit write not applied");
  chk_enable_read: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata[7:4] == 4'h0 && reg_rdata[0] == $past(osc_run))
    else $error("enable readback wrong");
  chk_one_phase: assert property ($onehot0({light_active, near_active, wait_active}))
    else $error("two phases at once");
  chk_pin_drive: assert property (!int_n_o)
    else $error("interrupt pin drives high");
  chk_pin_sticky: assert property (int_n_oe && !reg_wr && !$past(reg_wr) |=> int_n_oe)
    else $error("interrupt dropped without clear");
  chk_flag_clear: assert property (flag_clear_s |-> ##2 !int_n_oe)
    else $error("interrupt kept after clear");
  chk_light_len: assert property (light_end_s |-> int'(cnt_reg) >= exp_len - 2 && int'(cnt_reg) <= exp_len + 2)
    else $error("light phase length wrong");
  chk_oe_cause: assert property ($rose(int_n_oe) |-> $past(osc_run, 2) || $past(reg_wr, 2) || $past(reg_wr))
    else $error("interrupt without cause");
endmodule
bind lps_seq lps_seq_assertions #(.INT_DIV(INT_DIV), .STEP_ITICKS(STEP_ITICKS)) u_chk (.core_clk(core_clk),
  .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .osc_run(osc_run), .light_active(light_active), .near_active(near_active),
  .wait_active(wait_active), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
`default_nettype wire

// ---- dv/lps_host.sv ----
// Host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module lps_host (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle lines are inverted so a stale address never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_light_prox_sequencing_thresholds.sv ----
// Self-checking bench for the light/near sequencer
`timescale 1ns/1ps
`default_nettype none
module test_light_prox_sequencing_thresholds;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv, near_result;
  logic reg_wr, reg_rd, osc_run, light_active, near_active, wait_active, int_n_o, int_n_oe;
  logic [15:0] photopic_data = 16'h0000;
  logic [15:0] light_result;
  logic [7:0] near_data = 8'h00;
  logic [2:0] ph;
  logic [7:0] ra [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8a, 8'h8c, 8'h8d};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
  int err_count = 0;
  int checked = 0;
  int n;
  assign ph = {wait_active, near_active, light_active};
  always #5 core_clk = ~core_clk;
  // Short counts keep light and wait phases to a few cycles; near steps keep the package length
  lps_seq #(.OSC_HZ(100000000), .INT_DIV(2), .STEP_ITICKS(4)) u_dut (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .photopic_data(photopic_data), .near_data(near_data), .osc_run(osc_run), .light_active(light_active),
    .near_active(near_active), .wait_active(wait_active), .light_result(light_result),
    .near_result(near_result), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
  lps_host u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rdv);
    check({8'h00, rdv}, {8'h00, e});
  endtask
  task automatic in_range(input int lo, input int hi);
    check({15'h0000, n >= lo && n <= hi}, 16'h0001);
  endtask
  // Bounded: a stuck sequencer leaves n at zero and fails the length test
  task automatic run_phase(input int i);
    n = 0;
    for (int k = 0; k < 5000 && !ph[i]; k++) @(negedge core_clk);
    while (ph[i] && n < 5000) begin
      n++;
      @(negedge core_clk);
    end
    repeat (3) @(negedge core_clk);
  endtask
  // Power down first and let any phase end settle, since a set beats a clear
  task automatic off_clear;
    u_host.wr(8'h80, 8'h00);
    repeat (4) @(negedge core_clk);
    u_host.wr(8'h93, 8'h30);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    u_host.wr(8'h80, 8'hf0);
    rchk(8'h80, 8'h00);
    check({15'h0000, osc_run}, 16'h0000);
    u_host.wr(8'h84, 8'h34);
    rchk(8'h84, 8'h34);
    rchk(8'h85, 8'h00);
    u_host.wr(8'h85, 8'h01);
    u_host.wr(8'h86, 8'h00);
    u_host.wr(8'h87, 8'h03);
    u_host.wr(8'h8c, 8'h02);
    u_host.wr(8'hdd, 8'h10);
    photopic_data = 16'h0050;
    // Wait stays on so each measurement phase drops and can be timed
    u_host.wr(8'h80, 8'h0b);
    run_phase(0);
    in_range(6, 10);
    check(light_result, 16'h0050);
    check({15'h0000, int_n_oe}, 16'h0000);
    run_phase(0);
    check({15'h0000, int_n_oe}, 16'h0001);
    off_clear();
    repeat (2) @(negedge core_clk);
    check({15'h0000, int_n_oe}, 16'h0000);
    rchk(8'h93, 8'h00);
    photopic_data = 16'hffff;
    u_host.wr(8'h8c, 8'h01);
    u_host.wr(8'h80, 8'h0b);
    run_phase(0);
    check(light_result, 16'h03ff);
    check({15'h0000, int_n_oe}, 16'h0001);
    off_clear();
    u_host.wr(8'hdd, 8'h20);
    u_host.wr(8'h82, 8'h00);
    u_host.wr(8'h88, 8'h10);
    u_host.wr(8'h8a, 8'h80);
    u_host.wr(8'h8c, 8'h10);
    near_data = 8'h90;
    u_host.wr(8'h80, 8'h0d);
    run_phase(1);
    in_range(126, 130);
    check({8'h00, near_result}, 16'h0090);
    check({15'h0000, int_n_oe}, 16'h0001);
    check(light_result, 16'h03ff);
    off_clear();
    u_host.wr(8'h8d, 8'h84);
    u_host.wr(8'h80, 8'h0b);
    run_phase(2);
    in_range(94, 98);
    u_host.wr(8'h8d, 8'h80);
    run_phase(2);
    run_phase(2);
    in_range(6, 10);
    check({8'h00, near_result}, 16'h0090);
    print_verdict();
  end
endmodule
`default_nettype wire
